/* rtl/rx_gating_pkg.sv */
package rx_gating_pkg;

    // register map of the two-wire serial port
    localparam logic [7:0] EVEN_LANE_DISABLE_ADDR = 8'h1e;
    localparam logic [7:0] GATING_ADDR            = 8'h1f;
    localparam logic [7:0] CFG_DEFAULT            = 8'h00;
    localparam logic [7:0] UNMAPPED_READ          = 8'h00;

    // serial port framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a; // value is arbitrary

    // lane count per pixel channel, lanes a..e at bits 4..0
    localparam int LANES = 5;

    // wait counter terminal counts, in link clock cycles
    localparam int          WAIT_W  = 12;
    localparam logic [11:0] WAIT_1K = 12'h400;
    localparam logic [11:0] WAIT_2K = 12'h800;

    // output-availability policy, field bits 7:6
    typedef enum logic [1:0] {
        AVAIL_COUNT      = 2'h0,
        AVAIL_COUNT_2K   = 2'h1,
        AVAIL_ALIGNED    = 2'h2,
        AVAIL_CLK_SEEN   = 2'h3
    } avail_mode_t;

    // register 0x1f layout
    typedef struct packed {
        avail_mode_t mode;
        logic        wait_2k;
        logic [4:0]  odd_dis;
    } gating_cfg_t;

    // register 0x1e layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic [4:0] even_dis;
    } even_cfg_t;

    // asynchronous bus and status pins that are synchronised together
    typedef struct packed {
        logic scl;
        logic sda;
        logic link_clk;
        logic clk_present;
        logic pll_aligned;
    } async_pins_t;

    localparam int          ASYNC_W    = 5;
    localparam logic [4:0]  ASYNC_IDLE = 5'h18; // bus lines idle high

endpackage

/* rtl/rx_output_gating_config.sv */
`timescale 1ns/1ns
`default_nettype none

module rx_output_gating_config #(
    parameter logic [6:0] DEV_ADDR = rx_gating_pkg::DEV_ADDR_DEFAULT
) (
    // clock and resets
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       power_on_reset_n,
    // two-wire serial port
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // link status from the receiver front end
    input  wire logic       link_clk,
    input  wire logic       clk_present,
    input  wire logic       pll_aligned,
    // output gating
    output logic            outputs_live,
    output logic [4:0]      even_lane_en,
    output logic [4:0]      odd_lane_en
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } ser_state_t;

    // synchronised pins
    rx_gating_pkg::async_pins_t pins_raw;
    rx_gating_pkg::async_pins_t pins;
    rx_gating_pkg::async_pins_t pins_prev_r;

    assign pins_raw = '{scl: scl, sda: sda_in, link_clk: link_clk,
                        clk_present: clk_present, pll_aligned: pll_aligned};

    sync3 #(
        .WIDTH (rx_gating_pkg::ASYNC_W),
        .INIT  (rx_gating_pkg::ASYNC_IDLE)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pins_raw),
        .level    (pins)
    );

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic link_edge;

    // edges taken from the filtered levels only
    assign scl_rise   = pins.scl & ~pins_prev_r.scl;
    assign scl_fall   = ~pins.scl & pins_prev_r.scl;
    assign start_cond = pins.scl & pins_prev_r.scl & pins_prev_r.sda & ~pins.sda;
    assign stop_cond  = pins.scl & pins_prev_r.scl & ~pins_prev_r.sda & pins.sda;
    assign link_edge  = pins.link_clk & ~pins_prev_r.link_clk;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pins_prev_r <= rx_gating_pkg::ASYNC_IDLE;
        end else begin
            pins_prev_r <= pins;
        end
    end

    // mapped-address decode, used by the write path; the read path compares the pointer directly
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == rx_gating_pkg::EVEN_LANE_DISABLE_ADDR) ||
                    (a == rx_gating_pkg::GATING_ADDR);
    endfunction

    // configuration registers
    rx_gating_pkg::gating_cfg_t gating_r;
    rx_gating_pkg::gating_cfg_t gating_nxt;
    rx_gating_pkg::even_cfg_t   even_r;
    rx_gating_pkg::even_cfg_t   even_nxt;

    // serial engine state
    ser_state_t  state_r;
    ser_state_t  state_nxt;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [7:0]  ptr_r;
    logic [7:0]  ptr_nxt;
    logic        rw_r;
    logic        rw_nxt;
    logic        acked_r;
    logic        acked_nxt;
    logic        sda_out_nxt;
    logic        sda_oe_nxt;
    logic        wr_en;
    logic [7:0]  rd_data;

    // readback; reserved bits of 0x1e read as zero
    always_comb begin
        if (ptr_r == rx_gating_pkg::GATING_ADDR) begin
            rd_data = gating_r;
        end else if (ptr_r == rx_gating_pkg::EVEN_LANE_DISABLE_ADDR) begin
            rd_data = {3'h0, even_r.even_dis};
        end else begin
            rd_data = rx_gating_pkg::UNMAPPED_READ;
        end
    end

    // serial protocol: address, pointer, then data with auto-increment
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        shift_nxt   = shift_r;
        ptr_nxt     = ptr_r;
        rw_nxt      = rw_r;
        acked_nxt   = acked_r;
        sda_out_nxt = sda_out;
        sda_oe_nxt  = sda_oe;
        wr_en       = 1'b0;
        if (start_cond) begin
            state_nxt  = ST_ADDR;
            cnt_nxt    = 4'h0;
            sda_oe_nxt = 1'b0;
        end else if (stop_cond) begin
            state_nxt  = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    shift_nxt = {shift_r[6:0], pins.sda};
                    cnt_nxt   = cnt_r + 4'h1;
                end
                ST_RDATA: begin
                    cnt_nxt = cnt_r + 4'h1;
                end
                ST_RDATA_ACK: begin
                    acked_nxt = ~pins.sda;
                    if (!pins.sda) begin
                        ptr_nxt = ptr_r + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (cnt_r == rx_gating_pkg::BITS_PER_BYTE) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            state_nxt   = ST_ADDR_ACK;
                            rw_nxt      = shift_r[0];
                            sda_out_nxt = 1'b0;
                            sda_oe_nxt  = 1'b1;
                        end else begin
                            state_nxt = ST_IDLE; // another target on the bus
                        end
                    end
                end
                ST_PTR: begin
                    if (cnt_r == rx_gating_pkg::BITS_PER_BYTE) begin
                        state_nxt   = ST_PTR_ACK;
                        ptr_nxt     = shift_r;
                        sda_out_nxt = 1'b0;
                        sda_oe_nxt  = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (cnt_r == rx_gating_pkg::BITS_PER_BYTE) begin
                        state_nxt   = ST_WDATA_ACK;
                        wr_en       = 1'b1;
                        sda_out_nxt = 1'b0;
                        sda_oe_nxt  = 1'b1;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_nxt = 4'h0;
                    if (rw_r) begin
                        state_nxt   = ST_RDATA;
                        shift_nxt   = rd_data;
                        sda_out_nxt = rd_data[7];
                        sda_oe_nxt  = 1'b1;
                    end else begin
                        state_nxt  = ST_PTR;
                        sda_oe_nxt = 1'b0;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    state_nxt  = ST_WDATA;
                    cnt_nxt    = 4'h0;
                    sda_oe_nxt = 1'b0;
                    if (state_r == ST_WDATA_ACK) begin
                        ptr_nxt = ptr_r + 8'h01;
                    end
                end
                ST_RDATA: begin
                    if (cnt_r == rx_gating_pkg::BITS_PER_BYTE) begin
                        state_nxt  = ST_RDATA_ACK;
                        sda_oe_nxt = 1'b0;
                    end else begin
                        shift_nxt   = {shift_r[6:0], 1'b0};
                        sda_out_nxt = shift_r[6];
                    end
                end
                ST_RDATA_ACK: begin
                    cnt_nxt = 4'h0;
                    if (acked_r) begin
                        state_nxt   = ST_RDATA;
                        shift_nxt   = rd_data;
                        sda_out_nxt = rd_data[7];
                        sda_oe_nxt  = 1'b1;
                    end else begin
                        state_nxt = ST_IDLE; // host ended the read
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            ptr_r   <= 8'h00;
            rw_r    <= 1'b0;
            acked_r <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            acked_r <= acked_nxt;
            sda_out <= sda_out_nxt;
            sda_oe  <= sda_oe_nxt;
        end
    end

    // register writes; unmapped pointers are acked but store nothing
    always_comb begin
        gating_nxt = gating_r;
        even_nxt   = even_r;
        if (wr_en && is_mapped(ptr_r)) begin
            if (ptr_r == rx_gating_pkg::GATING_ADDR) begin
                gating_nxt = shift_r;
            end else begin
                even_nxt = {3'h0, shift_r[4:0]};
            end
        end
    end

    // only power-up clears these, so a functional reset keeps the setup
    always_ff @(posedge clk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            gating_r <= rx_gating_pkg::CFG_DEFAULT;
            even_r   <= rx_gating_pkg::CFG_DEFAULT;
        end else begin
            gating_r <= gating_nxt;
            even_r   <= even_nxt;
        end
    end

    // wait counter on link clock edges; only sees link clocks well below clk/2
    localparam int LANES_W = rx_gating_pkg::LANES;
    logic [rx_gating_pkg::WAIT_W-1:0] wait_r;
    logic [rx_gating_pkg::WAIT_W-1:0] wait_nxt;
    logic [rx_gating_pkg::WAIT_W-1:0] terminal;
    logic                              live_nxt;
    logic [LANES_W-1:0]                even_en_nxt;
    logic [LANES_W-1:0]                odd_en_nxt;

    always_comb begin
        if (gating_r.mode == rx_gating_pkg::AVAIL_COUNT_2K) begin
            terminal = rx_gating_pkg::WAIT_2K;
        end else if (gating_r.wait_2k) begin
            terminal = rx_gating_pkg::WAIT_2K;
        end else begin
            terminal = rx_gating_pkg::WAIT_1K;
        end
        wait_nxt = wait_r;
        if (!pins.clk_present) begin
            wait_nxt = '0;
        end else if (link_edge && wait_r < terminal) begin
            wait_nxt = wait_r + 1'b1;
        end
        case (gating_r.mode)
            rx_gating_pkg::AVAIL_CLK_SEEN: live_nxt = pins.clk_present;
            rx_gating_pkg::AVAIL_ALIGNED:
                live_nxt = pins.clk_present && wait_r >= terminal
                           && pins.pll_aligned;
            default: live_nxt = pins.clk_present && wait_r >= terminal;
        endcase
        // disabled lanes and a closed gate both hold the lane inactive
        even_en_nxt = live_nxt ? ~even_r.even_dis : '0;
        odd_en_nxt  = live_nxt ? ~gating_r.odd_dis : '0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_r       <= '0;
            outputs_live <= 1'b0;
            even_lane_en <= '0;
            odd_lane_en  <= '0;
        end else begin
            wait_r       <= wait_nxt;
            outputs_live <= live_nxt;
            even_lane_en <= even_en_nxt;
            odd_lane_en  <= odd_en_nxt;
        end
    end

endmodule

`default_nettype wire

/* rtl/sync3.sv */
`timescale 1ns/1ns
`default_nettype none

module sync3 #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // asynchronous input and its filtered level
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_nxt;

    // a bit changes only once the second and third stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level[i];
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r  <= INIT;
            s2_r  <= INIT;
            s3_r  <= INIT;
            level <= INIT;
        end else begin
            s1_r  <= async_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            level <= level_nxt;
        end
    end

endmodule

`default_nettype wire

/* verif/rx_gating_props.sv */
`timescale 1ns/1ns
`default_nettype none

module rx_gating_props (
    // clock and resets
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       power_on_reset_n,
    // serial port
    input  wire logic       scl,
    input  wire logic       sda_in,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    // link status and gating
    input  wire logic       link_clk,
    input  wire logic       clk_present,
    input  wire logic       pll_aligned,
    input  wire logic       outputs_live,
    input  wire logic [4:0] even_lane_en,
    input  wire logic [4:0] odd_lane_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // clock-present low long enough to pass the pin filter
    sequence s_noclk;
        !clk_present [*6];
    endsequence
    // idle bus with a live link, so nothing may change the gate
    sequence s_quiet;
        (outputs_live && clk_present && pll_aligned && scl) [*8];
    endsequence

    AST_LANES_OFF: assert property (!outputs_live |-> even_lane_en == 5'h00 && odd_lane_en == 5'h00)
        else $error("lane enabled while outputs gated");
    AST_NOCLK_GATE: assert property (s_noclk |-> !outputs_live)
        else $error("outputs live without link clock");
    AST_LIVE_NEEDS_CLK: assert property ($rose(outputs_live) |-> $past(clk_present, 3) || $past(clk_present, 4))
        else $error("outputs released without clock present");
    AST_NO_EARLY_LIVE: assert property (s_noclk ##1 clk_present |-> !outputs_live [*2])
        else $error("outputs released faster than the pin filter");
    AST_LIVE_HOLDS: assert property (s_quiet |=> outputs_live)
        else $error("outputs dropped with steady inputs");
    AST_ACK_ON_FALL: assert property ($rose(sda_oe) |-> !$past(scl))
        else $error("serial drive started while clock high");
    AST_REL_ON_FALL: assert property ($fell(sda_oe) |-> !$past(scl))
        else $error("serial drive released while clock high");
    AST_SDA_STEADY: assert property (scl [*6] |-> $stable(sda_oe) && $stable(sda_out))
        else $error("serial data changed during clock high");
endmodule

bind rx_output_gating_config rx_gating_props u_props (
    .clk(clk), .reset_n(reset_n), .power_on_reset_n(power_on_reset_n),
    .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .link_clk(link_clk), .clk_present(clk_present), .pll_aligned(pll_aligned),
    .outputs_live(outputs_live), .even_lane_en(even_lane_en), .odd_lane_en(odd_lane_en)
);

`default_nettype wire

/* verif/serial_host.sv */
`timescale 1ns/1ns
`default_nettype none

module serial_host #(
    parameter logic [6:0] ADDR = rx_gating_pkg::DEV_ADDR_DEFAULT
) (
    // clock
    input  wire logic clk,
    // bus lines, data is open drain with a pull-up
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // 8 clocks a phase, above the 6 the pin filter needs
    task automatic ph();
        repeat (8) @(posedge clk);
    endtask

    // start or repeated start, leaves scl low
    task automatic start();
        ph();
        sda_low <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b0;
    endtask

    task automatic stop();
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b0;
        ph();
    endtask

    // one clock pulse; sampled away from the edge to avoid a race
    task automatic bitx(input logic lo, output logic v);
        ph();
        sda_low <= lo;
        ph();
        scl <= 1'b1;
        ph();
        @(negedge clk);
        v = sda_line;
        @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitx(!b[i], ack);
        end
        bitx(1'b0, ack);
        ack = !ack;
    endtask

    // single byte read, always closed by a nack
    task automatic rbyte(output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b0, v);
            d[i] = v;
        end
        bitx(1'b0, v);
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(p, a1);
        wbyte(d, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        start();
        wbyte({ADDR, 1'b0}, a0);
        wbyte(p, a1);
        start();
        wbyte({ADDR, 1'b1}, a2);
        rbyte(d);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic       clk, reset_n, por_n, link_clk, clk_present, pll_aligned;
    logic       scl, sda_low, sda_line, sda_out, sda_oe, live;
    logic [4:0] even_en, odd_en, edis, odis;
    int         err_count, n_tests;

    // pull-up wins unless someone drives low
    assign sda_line = !((sda_oe && !sda_out) || sda_low);

    rx_output_gating_config dut (
        .clk(clk), .reset_n(reset_n), .power_on_reset_n(por_n),
        .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .link_clk(link_clk), .clk_present(clk_present), .pll_aligned(pll_aligned),
        .outputs_live(live), .even_lane_en(even_en), .odd_lane_en(odd_en)
    );
    serial_host host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        host.wr(p, d, ok);
        chk({7'h00, ok}, 8'h01);
    endtask

    task automatic rreg(input logic [7:0] p, input logic [7:0] exp);
        logic       ok;
        logic [7:0] d;
        host.rd(p, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask

    // link edges slow enough for the filter to see each one
    task automatic edges(input int n);
        repeat (n) begin
            link_clk <= 1'b1;
            repeat (4) @(posedge clk);
            link_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // gate and lane enables, sampled mid-cycle once pins settled
    task automatic gate(input logic e);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({7'h00, live}, {7'h00, e});
        chk({3'h0, even_en}, e ? {3'h0, ~edis} : 8'h00);
        chk({3'h0, odd_en}, e ? {3'h0, ~odis} : 8'h00);
        @(posedge clk);
    endtask

    initial begin
        repeat (99000) @(posedge clk);
        err_count++;
        $display("Error %0t: run timed out", $time);
        close_out();
    end

    initial begin
        reset_n = 1'b0;
        por_n = 1'b0;
        link_clk = 1'b0;
        clk_present = 1'b0;
        pll_aligned = 1'b0;
        edis = 5'h00;
        odis = 5'h00;
        err_count = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        rreg(8'h1e, 8'h00);
        rreg(8'h1f, 8'h00);
        rreg(8'h20, 8'h00);
        // default policy: 1K edges, not one fewer
        clk_present <= 1'b1;
        edges(1023);
        gate(1'b0);
        edges(1);
        gate(1'b1);
        wreg(8'h1e, 8'hff);
        edis = 5'h1f;
        rreg(8'h1e, 8'h1f);
        gate(1'b1);
        wreg(8'h1e, 8'h12);
        edis = 5'h12;
        gate(1'b1);
        wreg(8'h1f, 8'h15);
        odis = 5'h15;
        rreg(8'h1f, 8'h15);
        gate(1'b1);
        // losing the link clock drops the outputs
        clk_present <= 1'b0;
        gate(1'b0);
        wreg(8'h1f, 8'h35);
        clk_present <= 1'b1;
        edges(1024);
        gate(1'b0);
        edges(1024);
        gate(1'b1);
        clk_present <= 1'b0;
        wreg(8'h1f, 8'h55);
        clk_present <= 1'b1;
        edges(2047);
        gate(1'b0);
        edges(1);
        gate(1'b1);
        clk_present <= 1'b0;
        wreg(8'h1f, 8'h95);
        clk_present <= 1'b1;
        edges(1024);
        gate(1'b0);
        pll_aligned <= 1'b1;
        gate(1'b1);
        // hold alignment long enough for a steady live window
        gate(1'b1);
        pll_aligned <= 1'b0;
        gate(1'b0);
        clk_present <= 1'b0;
        wreg(8'h1f, 8'hd5);
        clk_present <= 1'b1;
        gate(1'b1);
        clk_present <= 1'b0;
        gate(1'b0);
        // functional reset keeps config, power reset clears it
        clk_present <= 1'b1;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        gate(1'b1);
        rreg(8'h1f, 8'hd5);
        clk_present <= 1'b0;
        gate(1'b0);
        por_n <= 1'b0;
        repeat (2) @(posedge clk);
        por_n <= 1'b1;
        rreg(8'h1f, 8'h00);
        rreg(8'h1e, 8'h00);
        close_out();
    end
endmodule

`default_nettype wire
